//--- common/apm_pkg.sv
`include "apm_regs.svh"

package apm_pkg;

    // ------------------------------------------------------------
    // pin bundle, synchronised as one group
    // ------------------------------------------------------------
    typedef struct packed {
        logic                   sclk;
        logic                   pd_sel;
        logic                   oe_n;
        logic [1:0]             mode_lvl;
        logic                   over;
        logic                   under;
        logic [`APM_WORD_W-1:0] code;
    } apm_pins_type;

    // converted word with its range flag
    typedef struct packed {
        logic                   range_flag;
        logic [`APM_WORD_W-1:0] word;
    } apm_word_type;

    // power states, one-hot
    typedef enum logic [2:0] {
        APM_PS_NORMAL = 3'b001,
        APM_PS_NAP    = 3'b010,
        APM_PS_SLEEP  = 3'b100
    } apm_pwr_type;

    // mode pin levels: ground, one third, two thirds, full supply
    typedef enum logic [1:0] {
        APM_LVL_GND = 2'h0,
        APM_LVL_1_3 = 2'h1,
        APM_LVL_2_3 = 2'h2,
        APM_LVL_VDD = 2'h3
    } apm_lvl_type;

endpackage : apm_pkg

//--- common/apm_regs.svh
// What this block does
// - new sample taken on each sample clock rise in normal state
// - word appears five sample clocks after capture
// - fourteen-bit word, bit 13 most significant
// - range flag high on over or under range
// - select low: convert, drive when enable low
// - select high: nap or sleep, outputs off
// - mode level sets code format and stabilizer
`ifndef APM_REGS_SVH
`define APM_REGS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define APM_OFS_STATUS      4'h0
`define APM_OFS_MASK        4'h4
`define APM_OFS_STATE       4'h8
`define APM_OFS_LAST        4'hc

// ------------------------------------------------------------
// event bit positions (status and mask)
// ------------------------------------------------------------
`define APM_EV_WORD         0
`define APM_EV_RANGE        1
`define APM_EV_SHORT        2
`define APM_EV_LONG         3
`define APM_EV_MODE         4
`define APM_EV_W            5

// ------------------------------------------------------------
// state register fields and last register flag bit
// ------------------------------------------------------------
`define APM_ST_STAB         0
`define APM_ST_TWOS         1
`define APM_ST_PWR_LO       2
`define APM_ST_PWR_HI       4
`define APM_ST_OUT_EN       5
`define APM_LAST_FLAG       14

// ------------------------------------------------------------
// data word and latency
// ------------------------------------------------------------
`define APM_WORD_W          14
`define APM_LATENCY         5
`define APM_OB_MAX          14'h3fff
`define APM_OB_MIN          14'h0000
`define APM_TC_MAX          14'h1fff
`define APM_TC_MIN          14'h2000
`define APM_MSB_FLIP        14'h2000

// ------------------------------------------------------------
// sample clock phase limits
// ------------------------------------------------------------
`define APM_CLK_NS          20
`define APM_PH_MIN_OFF_NS   40
`define APM_PH_MIN_ON_NS    5
`define APM_PH_MAX_NS       500
`define APM_CEIL_CYC(ns)    (((ns) + `APM_CLK_NS - 1) / `APM_CLK_NS)
`define APM_PH_MIN_OFF_CYC  (`APM_CEIL_CYC(`APM_PH_MIN_OFF_NS))
`define APM_PH_MIN_ON_CYC   (`APM_CEIL_CYC(`APM_PH_MIN_ON_NS))
`define APM_PH_MAX_CYC      ((`APM_PH_MAX_NS) / `APM_CLK_NS)
`define APM_PH_CNT_W        6

`endif

//--- verification/apm_cap_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "apm_regs.svh"

// ------------------------------------------------------------
// capture side: sample clock source and pin latch
// ------------------------------------------------------------
module apm_cap_model (
    // clock and control
    input wire logic                   core_clk_i,
    input wire logic                   run_i,
    // device pins
    input wire logic [`APM_WORD_W-1:0] word_i,
    input wire logic                   flag_i,
    input wire logic                   oe_i,
    output logic                       sample_clk_o,
    output logic [`APM_WORD_W-1:0]     code_o,
    output logic                       over_o,
    output logic                       under_o,
    // latched pins and rise marker
    output logic [`APM_WORD_W:0]       cap_o,
    output logic                       rise_o
);
    localparam int PH = 4; // 60 ns high, 100 ns low
    int r;

    initial begin
        {sample_clk_o, code_o, over_o, under_o, cap_o, rise_o} = '0;
    end

    // one clock period per pass, clock stands low when idle
    always begin
        @(posedge core_clk_i);
        if (run_i) begin
            r = $urandom_range(7);
            code_o <= 14'($urandom);
            over_o <= (r == 0);
            under_o <= (r == 1);
            @(posedge core_clk_i);
            // released pins show a toggling pattern
            cap_o <= oe_i ? {flag_i, word_i} : ~cap_o;
            sample_clk_o <= 1'b1;
            rise_o <= 1'b1;
            @(posedge core_clk_i);
            rise_o <= 1'b0;
            repeat (PH - 2) @(posedge core_clk_i);
            sample_clk_o <= 1'b0;
            repeat (PH - 1) @(posedge core_clk_i);
        end
    end
endmodule : apm_cap_model

`default_nettype wire

//--- verification/apm_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "apm_regs.svh"

// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module apm_chk (
    // clock and reset
    input wire logic                   core_clk_i,
    input wire logic                   arst_n_i,
    // pins in
    input wire logic                   sample_clk_i,
    input wire logic                   power_down_select_i,
    input wire logic                   out_en_n_i,
    input wire logic [1:0]             mode_level_i,
    // pins out
    input wire logic [`APM_WORD_W-1:0] sample_word_o,
    input wire logic                   sample_word_oe_o,
    input wire logic                   range_flag_o,
    input wire logic                   range_flag_oe_o,
    input wire logic                   stab_en_o,
    // bus
    input wire logic                   avs_read_i,
    input wire logic                   avs_write_i,
    input wire logic                   avs_waitrequest_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    // enables, power states and stabilizer
    oe_pair_a: assert property ((sample_word_oe_o == range_flag_oe_o) &&
        (!sample_word_oe_o || (!$past(power_down_select_i, 3) && !$past(out_en_n_i, 2))))
        else $error("enables differ or driven outside normal mode");
    oe_off_a: assert property (out_en_n_i [*5] |-> !sample_word_oe_o)
        else $error("driven while disabled");
    drive_on_a: assert property ((!power_down_select_i && !out_en_n_i) [*5] |-> sample_word_oe_o)
        else $error("not driven in normal mode");
    nap_off_a: assert property (power_down_select_i [*5] |-> !range_flag_oe_o)
        else $error("driven in nap or sleep");
    stab_lvl_a: assert property ($stable(mode_level_i) [*4] |->
        stab_en_o == (mode_level_i == 2'h1 || mode_level_i == 2'h2))
        else $error("stabilizer wrong");
    // words move only with the sample clock, flagged words saturate, one wait cycle per bus access
    word_hold_a: assert property (!sample_clk_i [*5] |->
        $stable(sample_word_o) && $stable(range_flag_o))
        else $error("word moved without clock");
    flag_sat_a: assert property (range_flag_o |-> sample_word_o inside
        {`APM_OB_MAX, `APM_OB_MIN, `APM_TC_MAX, `APM_TC_MIN})
        else $error("flagged word not saturated");
    bus_wait_a: assert property ($rose(avs_read_i || avs_write_i) |->
        avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bad waitrequest");
endmodule : apm_chk

bind apm_top apm_chk apm_chk_inst (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sample_clk_i(sample_clk_i),
    .power_down_select_i(power_down_select_i), .out_en_n_i(out_en_n_i),
    .mode_level_i(mode_level_i), .sample_word_o(sample_word_o),
    .sample_word_oe_o(sample_word_oe_o), .range_flag_o(range_flag_o),
    .range_flag_oe_o(range_flag_oe_o), .stab_en_o(stab_en_o), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o));

`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "apm_regs.svh"

module tb_top;
    logic        core_clk_i, arst_n_i, sclk, pd, oe_n, over, under, run, rise;
    logic        rdn, wrn, wreq, oe, foe, flag, stab, irq, pushing;
    logic [1:0]  mode;
    logic [3:0]  addr, be;
    logic [13:0] code, word;
    logic [14:0] cap;
    logic [31:0] wdata, rdata, rd;
    int          failures, n_checks, skip;
    logic [15:0] q[$];

    apm_top apm_top_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sample_clk_i(sclk),
        .power_down_select_i(pd), .out_en_n_i(oe_n), .mode_level_i(mode), .ain_code_i(code),
        .ain_over_i(over), .ain_under_i(under), .sample_word_o(word), .sample_word_oe_o(oe),
        .range_flag_o(flag), .range_flag_oe_o(foe), .stab_en_o(stab), .avs_address_i(addr),
        .avs_read_i(rdn), .avs_write_i(wrn), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rd), .avs_waitrequest_o(wreq), .irq_o(irq));

    apm_cap_model apm_cap_model_inst (.core_clk_i(core_clk_i), .run_i(run), .word_i(word),
        .flag_i(flag), .oe_i(oe & foe), .sample_clk_o(sclk), .code_o(code), .over_o(over),
        .under_o(under), .cap_o(cap), .rise_o(rise));

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // selected format of a capture, saturating on range
    function automatic logic [31:0] exp_word(input logic [15:0] e, input logic [1:0] m);
        logic [13:0] f;
        f = (m >= 2'h2) ? `APM_MSB_FLIP : 14'h0000;
        if (e[15]) return {17'h0, 1'b1, `APM_OB_MAX ^ f};
        if (e[14]) return {17'h0, 1'b1, `APM_OB_MIN ^ f};
        return {17'h0, 1'b0, e[13:0] ^ f};
    endfunction : exp_word

    // avalon access held until waitrequest is sampled low, read data kept in rdata
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge core_clk_i);
        addr <= a;
        wdata <= d;
        wrn <= w;
        rdn <= !w;
        @(posedge core_clk_i);
        while (wreq !== 1'b0 && t < 40) begin
            @(posedge core_clk_i);
            t++;
        end
        if (t == 40) failures++;
        rdata = rd;
        rdn <= 1'b0;
        wrn <= 1'b0;
    endtask : bus

    // run n sample clocks, then let the clock stand
    task automatic stream(input int n);
        int k;
        int t;
        k = 0;
        t = 0;
        run <= 1'b1;
        while (k < n && t < 2000) begin
            @(posedge core_clk_i);
            t++;
            if (rise === 1'b1) k++;
        end
        run <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        if (k < n) failures++;
    endtask : stream

    task automatic settle;
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask : settle

    // reference pipeline: capture k reaches the pins after rise k+5
    always @(posedge core_clk_i) begin
        if (rise === 1'b1 && pushing) begin
            if (skip > 0) skip--;
            else if (q.size() >= 6) check({17'h0, cap}, exp_word(q[q.size()-6], mode));
            q.push_back({over, under, code});
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        failures++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hc5f2b392));
        {arst_n_i, pd, oe_n, mode, addr, rdn, wrn, wdata, run, skip} = '0;
        {failures, n_checks} = '0;
        be = 4'h1;
        pushing = 1'b1;
        repeat (6) @(posedge core_clk_i);
        check({31'h0, oe}, 32'h0);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        for (int m = 0; m < 4; m++) begin
            mode <= 2'(m);
            repeat (6) @(posedge core_clk_i);
            check({31'h0, stab}, {31'h0, m == 1 || m == 2});
            bus(1'b0, `APM_OFS_STATE, 32'h0);
            check(rdata, 32'h24 | 32'(m >= 2) << 1 | 32'(m == 1 || m == 2));
            skip = 6;
            stream(10);
        end
        bus(1'b0, `APM_OFS_LAST, 32'h0);
        check(rdata, exp_word(q[q.size()-6], mode));
        // interrupt: raise, clear, mask
        bus(1'b1, `APM_OFS_MASK, 32'h1);
        settle();
        check({31'h0, irq}, 32'h1);
        bus(1'b1, `APM_OFS_STATUS, 32'h1f);
        bus(1'b0, `APM_OFS_STATUS, 32'h0);
        settle();
        check(rdata & 32'h1, 32'h0);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, `APM_OFS_MASK, 32'h0);
        stream(3);
        settle();
        check({31'h0, irq}, 32'h0);
        bus(1'b0, `APM_OFS_STATUS, 32'h0);
        check(rdata & 32'h1, 32'h1);
        bus(1'b1, `APM_OFS_MASK, 32'h1);
        settle();
        check({31'h0, irq}, 32'h1);
        // refused write and unmapped read
        be <= 4'h0;
        bus(1'b1, `APM_OFS_MASK, 32'h0);
        be <= 4'h1;
        bus(1'b0, `APM_OFS_MASK, 32'h0);
        check(rdata, 32'h1);
        bus(1'b0, 4'h2, 32'h0);
        check(rdata, 32'h0);
        // power states: outputs off, nap, sleep
        for (int s = 1; s < 4; s++) begin
            {pd, oe_n} <= 2'(s);
            repeat (6) @(posedge core_clk_i);
            bus(1'b0, `APM_OFS_STATE, 32'h0);
            check(32'(rdata[5:2]), 32'(s == 1 ? 4'h1 : s == 2 ? 4'h2 : 4'h4));
            check({31'h0, oe}, 32'h0);
        end
        // nap holds the pipeline, normal resumes it
        {pd, oe_n} <= 2'b10;
        pushing = 1'b0;
        stream(4);
        {pd, oe_n} <= 2'b00;
        repeat (6) @(posedge core_clk_i);
        check({31'h0, oe}, 32'h1);
        pushing = 1'b1;
        stream(8);
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire

//--- verilog/apm_pipe.sv
`timescale 1ns/1ps
`default_nettype none
`include "apm_regs.svh"

module apm_pipe
    import apm_pkg::*;
(
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         arst_n_i,
    // stage advance and data
    input  wire logic         adv_i,
    input  wire apm_word_type din_i,
    output apm_word_type      dout_o
);

    apm_word_type stage [`APM_LATENCY+2];

    assign stage[0] = din_i;

    // capture register, then one register per sample clock of latency
    genvar g;
    generate
        for (g = 1; g <= `APM_LATENCY + 1; g++) begin : g_stage
            always_ff @(posedge core_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    stage[g] <= '0;
                end else if (adv_i) begin
                    stage[g] <= stage[g-1];
                end
            end
        end
    endgenerate

    assign dout_o = stage[`APM_LATENCY+1];

endmodule : apm_pipe
`default_nettype wire

//--- verilog/apm_top.sv
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "apm_regs.svh"

module apm_top
    import apm_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   arst_n_i,
    // converter pins
    input  wire logic                   sample_clk_i,
    input  wire logic                   power_down_select_i,
    input  wire logic                   out_en_n_i,
    input  wire logic [1:0]             mode_level_i,
    // analog front end result
    input  wire logic [`APM_WORD_W-1:0] ain_code_i,
    input  wire logic                   ain_over_i,
    input  wire logic                   ain_under_i,
    // parallel outputs
    output logic [`APM_WORD_W-1:0]      sample_word_o,
    output logic                        sample_word_oe_o,
    output logic                        range_flag_o,
    output logic                        range_flag_oe_o,
    output logic                        stab_en_o,
    // avalon-mm slave
    input  wire logic [3:0]             avs_address_i,
    input  wire logic                   avs_read_i,
    input  wire logic                   avs_write_i,
    input  wire logic [31:0]            avs_writedata_i,
    input  wire logic [3:0]             avs_byteenable_i,
    output logic [31:0]                 avs_readdata_o,
    output logic                        avs_waitrequest_o,
    // interrupt
    output logic                        irq_o
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // mode level to {twos complement, stabilizer}
    function automatic logic [1:0] lvl_decode(input logic [1:0] lvl);
        logic [1:0] r;
        r = 2'h0;
        unique case (apm_lvl_type'(lvl))
            APM_LVL_GND: r = 2'h0;
            APM_LVL_1_3: r = 2'h1;
            APM_LVL_2_3: r = 2'h3;
            APM_LVL_VDD: r = 2'h2;
        endcase
        return r;
    endfunction : lvl_decode

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    apm_pins_type pins_raw;
    apm_pins_type pins_s1;
    apm_pins_type pins;
    logic         sclk_q;
    logic         sclk_rise;
    logic         sclk_edge;
    logic         twos;
    logic         stab;

    assign pins_raw = '{sclk: sample_clk_i, pd_sel: power_down_select_i,
                        oe_n: out_en_n_i, mode_lvl: mode_level_i,
                        over: ain_over_i, under: ain_under_i, code: ain_code_i};

    // two flops on every pin
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pins_s1 <= '0;
            pins    <= '0;
            sclk_q  <= 1'b0;
        end else begin
            pins_s1 <= pins_raw;
            pins    <= pins_s1;
            sclk_q  <= pins.sclk;
        end
    end

    assign sclk_rise = pins.sclk & ~sclk_q;
    assign sclk_edge = pins.sclk ^ sclk_q;
    assign {twos, stab} = lvl_decode(pins.mode_lvl);

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    apm_pwr_type pwr;
    apm_pwr_type next_pwr;
    logic        converting;
    logic        out_en;

    // nap when enable low, sleep when enable high
    always_comb begin
        if (!pins.pd_sel) begin
            next_pwr = APM_PS_NORMAL;
        end else if (!pins.oe_n) begin
            next_pwr = APM_PS_NAP;
        end else begin
            next_pwr = APM_PS_SLEEP;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pwr <= APM_PS_SLEEP;
        end else begin
            pwr <= next_pwr;
        end
    end

    // drivers on only in normal state with enable low
    always_comb begin
        converting = 1'b0;
        out_en     = 1'b0;
        unique case (pwr)
            APM_PS_NORMAL: begin
                converting = 1'b1;
                out_en     = ~pins.oe_n;
            end
            APM_PS_NAP:    out_en = 1'b0;
            APM_PS_SLEEP:  out_en = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // capture, format and pipeline
    // ------------------------------------------------------------
    apm_word_type cap;
    apm_word_type pipe_out;
    logic         adv;

    // saturate on range, flip msb for twos complement
    always_comb begin
        cap.range_flag = pins.over | pins.under;
        if (pins.over) begin
            cap.word = twos ? `APM_TC_MAX : `APM_OB_MAX;
        end else if (pins.under) begin
            cap.word = twos ? `APM_TC_MIN : `APM_OB_MIN;
        end else begin
            cap.word = twos ? (pins.code ^ `APM_MSB_FLIP) : pins.code;
        end
    end

    assign adv = sclk_rise & converting;

    apm_pipe u_pipe (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .adv_i      (adv),
        .din_i      (cap),
        .dout_o     (pipe_out)
    );

    // bit 13 is the msb of the parallel word
    assign sample_word_o    = pipe_out.word;
    assign range_flag_o     = pipe_out.range_flag;
    assign sample_word_oe_o = out_en;
    assign range_flag_oe_o  = out_en;
    assign stab_en_o        = stab;

    // ------------------------------------------------------------
    // sample clock phase monitor
    // ------------------------------------------------------------
    logic [`APM_PH_CNT_W-1:0] ph_cnt;
    logic [`APM_PH_CNT_W-1:0] ph_min;
    logic                     ev_short;
    logic                     ev_long;

    assign ph_min   = stab ? `APM_PH_CNT_W'(`APM_PH_MIN_ON_CYC)
                           : `APM_PH_CNT_W'(`APM_PH_MIN_OFF_CYC);
    assign ev_short = sclk_edge & converting & (ph_cnt < ph_min);
    assign ev_long  = converting & ~sclk_edge
                    & (ph_cnt == `APM_PH_CNT_W'(`APM_PH_MAX_CYC));

    // cycles spent in the current phase, saturating
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ph_cnt <= `APM_PH_CNT_W'(1);
        end else if (sclk_edge) begin
            ph_cnt <= `APM_PH_CNT_W'(1);
        end else if (ph_cnt != '1) begin
            ph_cnt <= ph_cnt + `APM_PH_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    logic [`APM_EV_W-1:0] status;
    logic [`APM_EV_W-1:0] mask;
    logic [`APM_EV_W-1:0] ev;
    logic [`APM_EV_W-1:0] clr;
    logic [1:0]           mode_q;
    logic                 wr_hit;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= 2'h0;
        end else begin
            mode_q <= lvl_decode(pins.mode_lvl);
        end
    end

    always_comb begin
        ev                = '0;
        ev[`APM_EV_WORD]  = adv;
        ev[`APM_EV_RANGE] = adv & pipe_out.range_flag;
        ev[`APM_EV_SHORT] = ev_short;
        ev[`APM_EV_LONG]  = ev_long;
        ev[`APM_EV_MODE]  = mode_q != lvl_decode(pins.mode_lvl);
    end

    assign clr = (wr_hit && avs_address_i == `APM_OFS_STATUS && avs_byteenable_i[0])
               ? avs_writedata_i[`APM_EV_W-1:0] : '0;

    // set wins over a write-one clear
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status <= '0;
        end else begin
            status <= (status & ~clr) | ev;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask <= '0;
        end else if (wr_hit && avs_address_i == `APM_OFS_MASK && avs_byteenable_i[0]) begin
            mask <= avs_writedata_i[`APM_EV_W-1:0];
        end
    end

    assign irq_o = |(status & mask);

    // ------------------------------------------------------------
    // avalon-mm slave: one wait cycle per access
    // ------------------------------------------------------------
    logic                  ack;
    logic                  req;
    logic [`APM_WORD_W:0]  last;

    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack;
    assign wr_hit            = avs_write_i & ack;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // copy of the word now standing on the outputs
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last <= '0;
        end else begin
            last <= {pipe_out.range_flag, pipe_out.word};
        end
    end

    // read data loaded on the first cycle, held at the accept edge
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !ack) begin
            avs_readdata_o <= '0;
            unique case (avs_address_i)
                `APM_OFS_STATUS: avs_readdata_o[`APM_EV_W-1:0] <= status;
                `APM_OFS_MASK:   avs_readdata_o[`APM_EV_W-1:0] <= mask;
                `APM_OFS_STATE: begin
                    avs_readdata_o[`APM_ST_STAB] <= stab;
                    avs_readdata_o[`APM_ST_TWOS] <= twos;
                    avs_readdata_o[`APM_ST_PWR_HI:`APM_ST_PWR_LO] <= pwr;
                    avs_readdata_o[`APM_ST_OUT_EN] <= out_en;
                end
                `APM_OFS_LAST:   avs_readdata_o[`APM_LAST_FLAG:0] <= last;
                default:         avs_readdata_o <= '0;
            endcase
        end
    end

endmodule : apm_top
`default_nettype wire
